// File: core/ridc_pkg.sv
// ridc_pkg: constants, state type and shared decode helpers for the clock-port decode block.
// assumes a single 50 MHz system clock and synchronous active-high reset everywhere.
package ridc_pkg;

   // configuration space of function 0
   localparam logic [7:0] CLOCK_CFG_OFFSET = 8'hCB;
   localparam logic [7:0] CLOCK_CFG_RESET = 8'h21;
   localparam logic [7:0] CLOCK_CFG_WRMASK = 8'h3D; // bits 7:6 and 1 reserved

   // field positions of clock_access_config
   localparam int CFG_POS_DECODE = 5;
   localparam int CFG_POS_LOCK_UP = 4;
   localparam int CFG_POS_LOCK_LO = 3;
   localparam int CFG_POS_UP_EN = 2;
   localparam int CFG_POS_STD_EN = 0;

   // I/O ports decoded here: the four clock ports and the two plug-and-play ports
   localparam logic [15:0] PORT_STD_INDEX = 16'h0070;
   localparam logic [15:0] PORT_STD_DATA = 16'h0071;
   localparam logic [15:0] PORT_EXT_INDEX = 16'h0072;
   localparam logic [15:0] PORT_EXT_DATA = 16'h0073;
   localparam logic [15:0] PORT_PNP_ADDR = 16'h0279;
   localparam logic [15:0] PORT_PNP_WDATA = 16'h0A79;

   // lockable byte window inside each 128-byte bank
   localparam logic [6:0] LOCK_FIRST = 7'h38;
   localparam logic [6:0] LOCK_LAST = 7'h3F;

   // claim timing in clock cycles after the address phase
   localparam logic [2:0] CLAIM_MEDIUM_CYC = 3'h2;
   localparam logic [2:0] CLAIM_SUB_CYC = 3'h4;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_DECODE = 3'b001,
      S_SUB = 3'b010,
      S_ISA = 3'b011,
      S_INT = 3'b100,
      S_DONE = 3'b101
   } ridc_state_t;

   // true when the byte offset lies in the lockable window
   function automatic logic ridc_in_lock(input logic [6:0] off);
      ridc_in_lock = (off >= LOCK_FIRST) && (off <= LOCK_LAST);
   endfunction

   // true for any of the four clock ports
   function automatic logic ridc_is_clock_port(input logic [15:0] addr);
      ridc_is_clock_port = (addr[15:2] == PORT_STD_INDEX[15:2]);
   endfunction

endpackage

// File: core/ridc_clock_cfg.sv
// ridc_clock_cfg: the clock_access_config register with its write-once lock bits.
// assumes config cycles arrive as single-cycle strobes with offset and byte data.
`timescale 1ns/1ps
`default_nettype none
module ridc_clock_cfg
   import ridc_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset
   input wire logic cfgWrite, // config write strobe
   input wire logic cfgRead, // config read strobe
   input wire logic [7:0] cfgOffset, // config byte offset
   input wire logic [7:0] cfgWData, // config write data
   output logic [7:0] cfgValue_q, // current register contents
   output logic [7:0] cfgRData_q // read answer, zero when unmapped
);

   logic [7:0] cfgValue_d;
   logic [7:0] cfgRData_d;
   logic hit;

   // next value: plain bits follow the write, lock bits can only be set
   always_comb begin
      hit = (cfgOffset == CLOCK_CFG_OFFSET);
      cfgValue_d = cfgValue_q;
      cfgRData_d = cfgRData_q;
      if (cfgWrite && hit) begin
         cfgValue_d = cfgWData & CLOCK_CFG_WRMASK; // RL18
         cfgValue_d[CFG_POS_LOCK_UP] = cfgValue_q[CFG_POS_LOCK_UP] | cfgWData[CFG_POS_LOCK_UP]; // RL13
         cfgValue_d[CFG_POS_LOCK_LO] = cfgValue_q[CFG_POS_LOCK_LO] | cfgWData[CFG_POS_LOCK_LO]; // RL13
      end
      if (cfgRead) begin
         cfgRData_d = hit ? cfgValue_q : 8'h00;
      end
   end

   // only a hardware reset clears the locks
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfgValue_q <= CLOCK_CFG_RESET; // RL7
         cfgRData_q <= 8'h00;
      end else begin
         cfgValue_q <= cfgValue_d;
         cfgRData_q <= cfgRData_d;
      end
   end

endmodule // ridc_clock_cfg
`default_nettype wire

// File: core/ridc_cmos_ram.sv
// ridc_cmos_ram: two 128-byte clock RAM banks with the 38h-3Fh lockout.
// assumes at most one of wrEn and rdEn per cycle; read data follows one cycle later.
`timescale 1ns/1ps
`default_nettype none
module ridc_cmos_ram
   import ridc_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset
   input wire logic wrEn, // write strobe
   input wire logic rdEn, // read strobe
   input wire logic bankUpper, // 1 selects extended bank
   input wire logic [6:0] offset, // byte within bank
   input wire logic [7:0] wData, // write data
   input wire logic lockLower, // standard bank window locked
   input wire logic lockUpper, // extended bank window locked
   output logic [7:0] rData_q // read data
);

   logic [7:0] mem [0:255];
   logic [7:0] rData_d;
   logic locked;
   logic [7:0] addr;

   // locked bytes read as zero so nothing stored leaks out
   always_comb begin
      addr = {bankUpper, offset};
      locked = ridc_in_lock(offset) && (bankUpper ? lockUpper : lockLower); // RL10 RL12
      rData_d = rData_q;
      if (rdEn) begin
         rData_d = locked ? 8'h00 : mem[addr]; // RL11
      end
   end

   // memory contents are battery-backed in spirit, so reset leaves them alone
   always_ff @(posedge clk_sys) begin
      if (wrEn && !locked) begin
         mem[addr] <= wData; // RL11
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rData_q <= 8'h00;
      end else begin
         rData_q <= rData_d;
      end
   end

endmodule // ridc_cmos_ram
`default_nettype wire

// File: core/ridc_io_decode.sv
// ridc_io_decode: claims PCI I/O cycles, serves the clock ports and forwards the rest to ISA.
// assumes one I/O request at a time, other agents' claims seen as a level, ISA engine outside.
//
// What this block does
// RL1 - decode-mode input: 0 subtractive by default, 1 positive
// RL2 - positive mode claims at medium timing, forwards only enabled ranges
// RL3 - subtractive mode also claims any cycle no other agent claimed
// RL4 - bus-type input: 0 reduced expansion bus by default, 1 full ISA
// RL5 - bus type muxes check pin and address pins LA17-23 with general I/O
// RL6 - decode mode works the same for either bus type
// RL7 - clock config register lives at CBh, resets to 21h
// RL8 - bit 5 picks positive or subtractive claim for ports 70-73h
// RL9 - software clears bit 5 when the clock is external
// RL10 - bit 4 locks extended-bank bytes 38h-3Fh
// RL11 - locked bytes ignore writes and never reveal their contents
// RL12 - bit 3 locks standard-bank bytes 38h-3Fh
// RL13 - lock bits are set-only, cleared by hardware reset alone
// RL14 - bit 2 serves 72-73h internally, else forwards to ISA
// RL15 - bit 0 serves 70-71h internally, else forwards to ISA
// RL16 - extended bank stays reachable while standard bank is off
// RL17 - in positive mode plug-and-play ports need their own enable
// RL18 - reserved bits 7:6 and 1 read zero, ignore writes
// RL19 - subtractive clock cycles forward only after no one else claimed
`timescale 1ns/1ps
`default_nettype none
module ridc_io_decode
   import ridc_pkg::*;
(
   input wire logic clk_sys, // 50 MHz system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic cfgWrite, // config write strobe, function 0
   input wire logic cfgRead, // config read strobe, function 0
   input wire logic [7:0] cfgOffset, // config byte offset
   input wire logic [7:0] cfgWData, // config write data
   output logic [7:0] cfgRData_q, // config read data
   input wire logic positiveDecodeSel, // 1 positive, 0 subtractive decode
   input wire logic fullIsaSel, // 1 full ISA, 0 reduced_expansion_io_bus
   input wire logic plugPlayPortDecodeEn, // forward 279h/A79h in positive mode
   input wire logic ioReq, // I/O cycle start, one cycle
   input wire logic ioWrite, // 1 write, 0 read
   input wire logic [15:0] ioAddr, // I/O address
   input wire logic [7:0] ioWData, // write data
   input wire logic rangeHit, // address in another enabled range
   input wire logic otherAgentClaim, // some other agent claimed
   output logic devselClaim_q, // this bridge claims the cycle
   output logic ioDone_q, // cycle complete, one cycle
   output logic [7:0] ioRData_q, // read data, valid with ioDone_q
   output logic isaFwdReq_q, // forward request to ISA engine
   output logic isaFwdWrite_q, // forwarded direction
   output logic [15:0] isaFwdAddr_q, // forwarded address
   output logic [7:0] isaFwdWData_q, // forwarded write data
   input wire logic isaDone, // ISA engine finished
   input wire logic [7:0] isaRData, // ISA read data
   input wire logic [6:0] isaUpperAddr, // LA23..LA17 from ISA engine
   input wire logic [6:0] gpoDrive, // general_outputs_one_to_seven values
   input wire logic chanCheckPinN, // level on the channel-check pin
   output logic [6:0] laPins_q, // LA23..LA17 or general outputs
   output logic generalInputZero_q, // general_input_zero read back
   output logic isaChanCheckN_q // channel check to ISA, high when unused
);

   logic [7:0] cfgValue;
   logic [7:0] ramRData;
   logic clkPosDecode;
   logic lockUp;
   logic lockLo;
   logic upEn;
   logic stdEn;

   ridc_state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic [15:0] addr_q, addr_d;
   logic write_q, write_d;
   logic [7:0] wdata_q, wdata_d;
   logic otherSeen_q, otherSeen_d;
   logic [6:0] idxStd_q, idxStd_d;
   logic [6:0] idxExt_q, idxExt_d;
   logic devsel_d;
   logic ioDone_d;
   logic [7:0] ioRData_d;
   logic isaFwdReq_d;
   logic isaFwdWrite_d;
   logic [15:0] isaFwdAddr_d;
   logic [7:0] isaFwdWData_d;
   logic [6:0] laPins_d;
   logic generalInputZero_d;
   logic isaChanCheckN_d;

   logic isClock;
   logic isPnp;
   logic posHit;
   logic subOk;
   logic internal;
   logic claimNow;
   logic ramWr;
   logic ramRd;
   logic ramUpper;
   logic [6:0] ramOff;

   ridc_clock_cfg u_cfg (
      .clk_sys(clk_sys),
      .rst(rst),
      .cfgWrite(cfgWrite),
      .cfgRead(cfgRead),
      .cfgOffset(cfgOffset),
      .cfgWData(cfgWData),
      .cfgValue_q(cfgValue),
      .cfgRData_q(cfgRData_q)
   );

   ridc_cmos_ram u_ram (
      .clk_sys(clk_sys),
      .rst(rst),
      .wrEn(ramWr),
      .rdEn(ramRd),
      .bankUpper(ramUpper),
      .offset(ramOff),
      .wData(wdata_q),
      .lockLower(lockLo),
      .lockUpper(lockUp),
      .rData_q(ramRData)
   );

   // configuration fields
   assign clkPosDecode = cfgValue[CFG_POS_DECODE];
   assign lockUp = cfgValue[CFG_POS_LOCK_UP];
   assign lockLo = cfgValue[CFG_POS_LOCK_LO];
   assign upEn = cfgValue[CFG_POS_UP_EN];
   assign stdEn = cfgValue[CFG_POS_STD_EN];

   // address classification; bus type never enters here, so every mix works
   always_comb begin
      isClock = ridc_is_clock_port(addr_q);
      isPnp = (addr_q == PORT_PNP_ADDR) || (addr_q == PORT_PNP_WDATA);
      // the two banks are gated separately, so one can be off without the other
      internal = isClock && (addr_q[1] ? upEn : stdEn); // RL14 RL15 RL16
      if (isClock) begin
         posHit = clkPosDecode; // RL8
         subOk = !clkPosDecode; // RL8
      end else if (isPnp) begin
         posHit = plugPlayPortDecodeEn; // RL17
         subOk = !positiveDecodeSel; // RL3
      end else begin
         posHit = rangeHit; // RL2
         subOk = !positiveDecodeSel; // RL1 RL3 RL6
      end
   end

   // cycle sequencer: medium claim window, then subtractive window
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      write_d = write_q;
      wdata_d = wdata_q;
      otherSeen_d = otherSeen_q;
      idxStd_d = idxStd_q;
      idxExt_d = idxExt_q;
      devsel_d = devselClaim_q;
      ioDone_d = 1'b0;
      ioRData_d = ioRData_q;
      isaFwdReq_d = isaFwdReq_q;
      isaFwdWrite_d = isaFwdWrite_q;
      isaFwdAddr_d = isaFwdAddr_q;
      isaFwdWData_d = isaFwdWData_q;
      claimNow = 1'b0;
      ramWr = 1'b0;
      ramRd = 1'b0;
      ramUpper = addr_q[1];
      ramOff = addr_q[1] ? idxExt_q : idxStd_q;
      case (state_q)
         S_IDLE: begin
            if (ioReq) begin
               addr_d = ioAddr;
               write_d = ioWrite;
               wdata_d = ioWData;
               otherSeen_d = otherAgentClaim;
               cnt_d = 3'h1;
               state_d = S_DECODE;
            end
         end
         S_DECODE: begin
            cnt_d = cnt_q + 3'h1;
            otherSeen_d = otherSeen_q | otherAgentClaim;
            if (cnt_q == CLAIM_MEDIUM_CYC) begin
               if (posHit) begin
                  claimNow = 1'b1; // RL2
               end else if (subOk) begin
                  state_d = S_SUB;
               end else begin
                  state_d = S_IDLE; // positive mode, not ours
               end
            end
         end
         S_SUB: begin
            cnt_d = cnt_q + 3'h1;
            // a claim seen anywhere in the window means the cycle is someone else's
            if (otherSeen_q || otherAgentClaim) begin
               state_d = S_IDLE; // RL3 RL19
            end else if (cnt_q == CLAIM_SUB_CYC) begin
               claimNow = 1'b1; // RL3 RL19
            end
         end
         S_ISA: begin
            if (isaDone) begin
               isaFwdReq_d = 1'b0;
               ioRData_d = write_q ? ioRData_q : isaRData;
               state_d = S_DONE;
            end
         end
         S_INT: begin
            if (!write_q) begin
               if (addr_q[0]) begin
                  ioRData_d = ramRData;
               end else begin
                  ioRData_d = {1'b0, addr_q[1] ? idxExt_q : idxStd_q};
               end
            end
            state_d = S_DONE;
         end
         S_DONE: begin
            ioDone_d = 1'b1;
            devsel_d = 1'b0;
            state_d = S_IDLE;
         end
         default: begin
            state_d = S_IDLE;
            devsel_d = 1'b0;
            isaFwdReq_d = 1'b0;
         end
      endcase
      // a claimed cycle is served by the clock banks or handed to ISA
      if (claimNow) begin
         devsel_d = 1'b1;
         if (internal) begin
            state_d = S_INT;
            if (addr_q[0]) begin
               ramWr = write_q;
               ramRd = !write_q;
            end else if (write_q) begin
               if (addr_q[1]) begin
                  idxExt_d = wdata_q[6:0];
               end else begin
                  idxStd_d = wdata_q[6:0];
               end
            end
         end else begin
            state_d = S_ISA; // RL14 RL15
            isaFwdReq_d = 1'b1;
            isaFwdWrite_d = write_q;
            isaFwdAddr_d = addr_q;
            isaFwdWData_d = wdata_q;
         end
      end
   end

   // pin function mux follows the bus type alone
   always_comb begin
      laPins_d = fullIsaSel ? isaUpperAddr : gpoDrive; // RL4 RL5
      generalInputZero_d = fullIsaSel ? 1'b0 : chanCheckPinN; // RL5
      isaChanCheckN_d = fullIsaSel ? chanCheckPinN : 1'b1; // RL5
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= S_IDLE;
         cnt_q <= 3'h0;
         addr_q <= 16'h0000;
         write_q <= 1'b0;
         wdata_q <= 8'h00;
         otherSeen_q <= 1'b0;
         idxStd_q <= 7'h00;
         idxExt_q <= 7'h00;
         devselClaim_q <= 1'b0;
         ioDone_q <= 1'b0;
         ioRData_q <= 8'h00;
         isaFwdReq_q <= 1'b0;
         isaFwdWrite_q <= 1'b0;
         isaFwdAddr_q <= 16'h0000;
         isaFwdWData_q <= 8'h00;
         laPins_q <= 7'h00;
         generalInputZero_q <= 1'b0;
         isaChanCheckN_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         write_q <= write_d;
         wdata_q <= wdata_d;
         otherSeen_q <= otherSeen_d;
         idxStd_q <= idxStd_d;
         idxExt_q <= idxExt_d;
         devselClaim_q <= devsel_d;
         ioDone_q <= ioDone_d;
         ioRData_q <= ioRData_d;
         isaFwdReq_q <= isaFwdReq_d;
         isaFwdWrite_q <= isaFwdWrite_d;
         isaFwdAddr_q <= isaFwdAddr_d;
         isaFwdWData_q <= isaFwdWData_d;
         laPins_q <= laPins_d;
         generalInputZero_q <= generalInputZero_d;
         isaChanCheckN_q <= isaChanCheckN_d;
      end
   end

endmodule // ridc_io_decode
`default_nettype wire

// File: verif/ridc_io_decode_props.sv
// ridc_io_decode_props: port checks for the clock-port decode block.
// assumes one clock, sync reset; bound onto ridc_io_decode.
`timescale 1ns/1ps
`default_nettype none
module ridc_io_decode_props
   import ridc_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic rst, // reset
   input wire logic cfgRead, // cfg read
   input wire logic [7:0] cfgOffset, // cfg offset
   input wire logic [7:0] cfgRData_q, // cfg answer
   input wire logic fullIsaSel, // bus type
   input wire logic ioReq, // io start
   input wire logic otherAgentClaim, // foreign claim
   input wire logic devselClaim_q, // our claim
   input wire logic ioDone_q, // done pulse
   input wire logic isaFwdReq_q, // forward req
   input wire logic [15:0] isaFwdAddr_q, // forward addr
   input wire logic isaDone, // isa done
   input wire logic [6:0] isaUpperAddr, // LA source
   input wire logic [6:0] gpoDrive, // gpo source
   input wire logic chanCheckPinN, // check pin
   input wire logic [6:0] laPins_q, // LA pins
   input wire logic generalInputZero_q, // gpi read back
   input wire logic isaChanCheckN_q // check to ISA
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic rdCb_q, rdCb_d;
   logic [1:0] lockSeen_q, lockSeen_d;
   // lock bits once read back set; only reset may drop them
   always_comb begin
      rdCb_d = !rst && cfgRead && (cfgOffset == CLOCK_CFG_OFFSET);
      lockSeen_d = rst ? 2'h0 : lockSeen_q | (rdCb_q ? cfgRData_q[4:3] : 2'h0);
   end
   always_ff @(posedge clk_sys) begin
      rdCb_q <= rdCb_d;
      lockSeen_q <= lockSeen_d;
   end
   sequence s_isa_finish;
      isaFwdReq_q && isaDone ##1 !isaFwdReq_q;
   endsequence
   sequence s_sub_claim;
      $rose(devselClaim_q) && $past(ioReq, 5) && !$past(ioReq, 3);
   endsequence
   a_cfg_unmapped: assert property (cfgRead && cfgOffset != CLOCK_CFG_OFFSET |=> cfgRData_q == 8'h00)
      else $error("unmapped config read not zero");
   a_resv_zero: assert property (rdCb_q |-> cfgRData_q[7:6] == 2'h0 && !cfgRData_q[1])
      else $error("reserved config bits read set");
   a_lock_sticky: assert property (rdCb_q |-> (cfgRData_q[4:3] & lockSeen_q) == lockSeen_q)
      else $error("lock bit dropped without reset");
   a_la_mux: assert property (!$past(rst) |-> laPins_q == ($past(fullIsaSel) ? $past(isaUpperAddr)
      : $past(gpoDrive)))
      else $error("address pins carry wrong source");
   a_chk_mux: assert property (!$past(rst) |->
      generalInputZero_q == (!$past(fullIsaSel) && $past(chanCheckPinN))
      && isaChanCheckN_q == ($past(fullIsaSel) ? $past(chanCheckPinN) : 1'b1))
      else $error("check pin routed wrong");
   a_done_ends: assert property (ioDone_q |-> !devselClaim_q && $past(devselClaim_q))
      else $error("done without a claim");
   a_claim_time: assert property ($rose(devselClaim_q) |-> $past(ioReq, 3) || $past(ioReq, 5))
      else $error("claim at wrong cycle");
   a_sub_quiet: assert property (s_sub_claim |-> !($past(otherAgentClaim, 1) || $past(otherAgentClaim, 2)
      || $past(otherAgentClaim, 3) || $past(otherAgentClaim, 4) || $past(otherAgentClaim, 5)))
      else $error("subtractive claim over foreign claim");
   a_fwd_stable: assert property (isaFwdReq_q && !isaDone |=> isaFwdReq_q && $stable(isaFwdAddr_q))
      else $error("forward request not held");
   a_isa_finish: assert property (s_isa_finish |=> ioDone_q)
      else $error("forward finish not followed by done");
endmodule // ridc_io_decode_props
bind ridc_io_decode ridc_io_decode_props ridc_io_decode_props_i (.clk_sys, .rst, .cfgRead, .cfgOffset, .cfgRData_q,
   .fullIsaSel, .ioReq, .otherAgentClaim, .devselClaim_q, .ioDone_q, .isaFwdReq_q, .isaFwdAddr_q, .isaDone,
   .isaUpperAddr, .gpoDrive, .chanCheckPinN, .laPins_q, .generalInputZero_q, .isaChanCheckN_q);
`default_nettype wire

// File: verif/ridc_isa_model.sv
// ridc_isa_model: expansion bus engine answering forwarded cycles.
// assumes forward request held until done is seen.
`timescale 1ns/1ps
`default_nettype none
module ridc_isa_model (
   input wire logic clk_sys, // clock
   input wire logic rst, // reset
   input wire logic slow, // long answer delay
   input wire logic isaFwdReq_q, // forward request
   input wire logic [15:0] isaFwdAddr_q, // forward address
   output logic isaDone, // done pulse
   output logic [7:0] isaRData, // read data
   output int fwdCnt // finished forwards
);
   int waitCnt;
   // data toggles when idle so stale values never look valid
   always @(posedge clk_sys) begin
      isaDone <= 1'b0;
      if (rst) begin
         waitCnt <= 0;
         fwdCnt <= 0;
         isaRData <= 8'h00;
      end else if (isaFwdReq_q && !isaDone) begin
         if (waitCnt >= (slow ? 7 : 1)) begin
            isaDone <= 1'b1;
            isaRData <= isaFwdAddr_q[7:0] ^ 8'hA5;
            waitCnt <= 0;
            fwdCnt <= fwdCnt + 1;
         end else begin
            waitCnt <= waitCnt + 1;
         end
      end else begin
         isaRData <= ~isaRData;
      end
   end
endmodule // ridc_isa_model
`default_nettype wire

// File: verif/ridc_io_decode_tb.sv
// ridc_io_decode_tb: self-checking bench for the clock-port decode block.
// assumes the isa model on the forward side; bench acts as pci master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module ridc_io_decode_tb import ridc_pkg::*; ;
   logic clk_sys = 0, rst = 1, cfgWrite = 0, cfgRead = 0, slow = 0;
   logic [7:0] cfgOffset = 0, cfgWData = 0, ioWData = 0, cfgRData_q, ioRData_q, isaFwdWData_q, isaRData;
   logic positiveDecodeSel = 0, fullIsaSel = 0, plugPlayPortDecodeEn = 0, ioReq = 0, ioWrite = 0;
   logic rangeHit = 0, otherAgentClaim = 0, chanCheckPinN = 1, isaDone;
   logic [15:0] ioAddr = 0, isaFwdAddr_q, a;
   logic [6:0] isaUpperAddr = 0, gpoDrive = 0, laPins_q;
   logic devselClaim_q, ioDone_q, isaFwdReq_q, isaFwdWrite_q, generalInputZero_q, isaChanCheckN_q, h;
   logic [31:0] r, r2;
   logic [7:0] c, d1, d2, d3;
   int seed = 32'h3925F700, error_cnt = 0, compares = 0, fwdCnt;
   always #10 clk_sys = ~clk_sys;
   // pin sources wander every cycle
   always @(posedge clk_sys) begin
      isaUpperAddr <= 7'($random(seed));
      gpoDrive <= 7'($random(seed));
      chanCheckPinN <= 1'($random(seed));
   end
   ridc_io_decode ridc_io_decode_i (.clk_sys, .rst, .cfgWrite, .cfgRead, .cfgOffset, .cfgWData, .cfgRData_q,
      .positiveDecodeSel, .fullIsaSel, .plugPlayPortDecodeEn, .ioReq, .ioWrite, .ioAddr, .ioWData, .rangeHit,
      .otherAgentClaim, .devselClaim_q, .ioDone_q, .ioRData_q, .isaFwdReq_q, .isaFwdWrite_q, .isaFwdAddr_q,
      .isaFwdWData_q, .isaDone, .isaRData, .isaUpperAddr, .gpoDrive, .chanCheckPinN, .laPins_q,
      .generalInputZero_q, .isaChanCheckN_q);
   ridc_isa_model ridc_isa_model_i (.clk_sys, .rst, .slow, .isaFwdReq_q, .isaFwdAddr_q, .isaDone, .isaRData,
      .fwdCnt);
   task automatic close_out;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cfg_wr(input logic [7:0] off, input logic [7:0] d);
      @(posedge clk_sys);
      cfgWrite <= 1'b1; cfgOffset <= off; cfgWData <= d;
      @(posedge clk_sys);
      cfgWrite <= 1'b0;
   endtask
   task automatic cfg_rd(input logic [7:0] off, input logic [7:0] e);
      @(posedge clk_sys);
      cfgRead <= 1'b1; cfgOffset <= off;
      @(posedge clk_sys);
      cfgRead <= 1'b0;
      #1 `CHK(cfgRData_q, e)
   endtask
   // one pci io cycle; claim cycle count 0 means dropped silently
   task automatic io(input logic wr, input logic [15:0] ad, input logic [7:0] d, input int expN,
      input logic toIsa, input logic rdChk, input logic [7:0] expD);
      int n, got, f0, fw;
      logic done;
      f0 = fwdCnt;
      got = 0;
      fw = 0;
      @(posedge clk_sys);
      ioReq <= 1'b1; ioWrite <= wr; ioAddr <= ad; ioWData <= d;
      @(posedge clk_sys);
      ioReq <= 1'b0;
      #1;
      for (n = 1; n <= 40 && ioDone_q !== 1'b1; n++) begin
         if (got == 0 && devselClaim_q === 1'b1) got = n;
         // forwarded cycle must carry the request as latched
         if (fw == 0 && isaFwdReq_q === 1'b1) begin
            fw = 1;
            `CHK({isaFwdWrite_q, isaFwdAddr_q}, {wr, ad})
            if (wr) `CHK(isaFwdWData_q, d)
         end
         @(posedge clk_sys); #1;
      end
      done = (ioDone_q === 1'b1);
      `CHK(got, expN)
      `CHK(done, expN != 0)
      if (expN != 0 && !done) close_out();
      if (done) `CHK(fwdCnt - f0, int'(toIsa))
      if (done && rdChk) `CHK(ioRData_q, expD)
   endtask
   task automatic ram_wr(input logic [15:0] ix, input logic [7:0] o, input logic [7:0] d);
      io(1'b1, ix, o, 3, 1'b0, 1'b0, 8'h00);
      io(1'b1, ix + 16'h0001, d, 3, 1'b0, 1'b0, 8'h00);
   endtask
   task automatic ram_rd(input logic [15:0] ix, input logic [7:0] o, input logic [7:0] e);
      io(1'b1, ix, o, 3, 1'b0, 1'b0, 8'h00);
      io(1'b0, ix + 16'h0001, 8'h00, 3, 1'b0, 1'b1, e);
   endtask
   function automatic int exp_claim(input logic [7:0] cf, input logic [15:0] ad, input logic pos, input logic plug_play_port_decode,
      input logic hit, input logic oth);
      if (ad[15:2] == PORT_STD_INDEX[15:2]) return cf[5] ? 3 : (oth ? 0 : 5);
      if (hit || (plug_play_port_decode && (ad == PORT_PNP_ADDR || ad == PORT_PNP_WDATA))) return 3;
      return (pos || oth) ? 0 : 5;
   endfunction
   function automatic logic exp_isa(input logic [7:0] cf, input logic [15:0] ad);
      if (ad[15:2] == PORT_STD_INDEX[15:2]) return !(ad[1] ? cf[2] : cf[0]);
      return 1'b1;
   endfunction
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      cfg_rd(CLOCK_CFG_OFFSET, 8'h21);
      cfg_rd(8'hCC, 8'h00);
      $display("test reset finished");
      // every decode mode, bus type, bank and claim mix; bit 5 often cleared as software may
      repeat (80) begin
         r = $random(seed);
         r2 = $random(seed);
         a = !r[2] ? {14'h001C, r[1:0]} : r[1:0] == 2'h0 ? PORT_PNP_ADDR : r[1:0] == 2'h1 ? PORT_PNP_WDATA
            : {6'h01, r[19:10]};
         h = r2[0] && a[15:10] == 6'h01;
         c = r[31:24] & 8'hE7;
         cfg_wr(CLOCK_CFG_OFFSET, c);
         cfg_rd(CLOCK_CFG_OFFSET, c & 8'h25);
         positiveDecodeSel <= r2[1]; plugPlayPortDecodeEn <= r2[2]; otherAgentClaim <= r2[3];
         fullIsaSel <= r2[6]; slow <= r2[5]; rangeHit <= h;
         // read data is only predictable when the isa model answers; clock ram here holds whatever random data-port writes left
         io(r2[4], a, r2[15:8], exp_claim(c, a, r2[1], r2[2], h, r2[3]), exp_isa(c, a),
            !r2[4] && exp_isa(c, a), a[7:0] ^ 8'hA5);
      end
      otherAgentClaim <= 1'b0;
      rangeHit <= 1'b0;
      $display("test routing finished");
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      d3 = 8'($random(seed));
      cfg_wr(CLOCK_CFG_OFFSET, 8'h25);
      ram_wr(PORT_STD_INDEX, 8'h37, d1);
      ram_wr(PORT_EXT_INDEX, 8'h3A, d2);
      ram_wr(PORT_STD_INDEX, 8'h3A, d3);
      ram_rd(PORT_STD_INDEX, 8'h37, d1);
      ram_rd(PORT_EXT_INDEX, 8'h3A, d2);
      ram_rd(PORT_STD_INDEX, 8'h3A, d3);
      $display("test ram finished");
      cfg_wr(CLOCK_CFG_OFFSET, 8'hFF);
      cfg_rd(CLOCK_CFG_OFFSET, 8'h3D);
      cfg_wr(CLOCK_CFG_OFFSET, 8'h00);
      cfg_rd(CLOCK_CFG_OFFSET, 8'h18);
      cfg_wr(CLOCK_CFG_OFFSET, 8'h25);
      ram_wr(PORT_STD_INDEX, 8'h3A, ~d3);
      ram_rd(PORT_STD_INDEX, 8'h3A, 8'h00);
      ram_wr(PORT_EXT_INDEX, 8'h3A, ~d2);
      ram_rd(PORT_EXT_INDEX, 8'h3A, 8'h00);
      ram_rd(PORT_STD_INDEX, 8'h37, d1);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      cfg_rd(CLOCK_CFG_OFFSET, 8'h21);
      cfg_wr(CLOCK_CFG_OFFSET, 8'h25);
      ram_rd(PORT_STD_INDEX, 8'h3A, d3);
      ram_rd(PORT_EXT_INDEX, 8'h3A, d2);
      $display("test lock finished");
      close_out();
   end
endmodule // ridc_io_decode_tb
`default_nettype wire
